// >>> hdl/sff_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Core undervoltage filter time from bits 5:4: 5, 15, 25, 40 us.
// - Core overvoltage filter time from bit 3: 25 or 45 us.
// - I/O undervoltage filter time from first byte bits 2:1.
// - I/O overvoltage filter time from first byte bit 0: 25/45 us.
// - Auxiliary undervoltage filter time from second byte bits 2:1.
// - Auxiliary overvoltage filter time from second byte bit 0.
// - Qualified low bias undervoltage starts a full power-down.
// - Battery below low threshold feeds bias directly, else pre-regulator.
// - Overcurrent past minimum on-time turns high side off till next edge.
// - Switching clock internal at reset; source changes only by command.
// - Configuration picks forced PWM 455 kHz or pulse skipping 2.22 MHz.
// - Pulse skipping omits turn-on when duty is below minimum.
// - Feedback UV high, UV low and OV flags go to main state machine.
module sff_ctrl #(
    parameter logic [12:0] UV40_CYC = 13'(sff_pkg::CYC_40US), // 40 us
    parameter logic [12:0] OV45_CYC = 13'(sff_pkg::CYC_45US) // 45 us
) (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic cfg_load, // Configuration byte strobe
    input wire logic [7:0] cfg_addr, // Configuration byte offset
    input wire logic [7:0] cfg_data, // Configuration byte value
    input wire logic pulse_skip_mode, // Mode setting, 1 = pulse skip
    input wire logic core_uv_cmp, // Core rail undervoltage comparator
    input wire logic core_ov_cmp, // Core rail overvoltage comparator
    input wire logic io_uv_cmp, // I/O rail undervoltage comparator
    input wire logic io_ov_cmp, // I/O rail overvoltage comparator
    input wire logic aux_uv_cmp, // Aux monitor undervoltage comparator
    input wire logic aux_ov_cmp, // Aux monitor overvoltage comparator
    input wire logic bias_uv_low_cmp, // Bias rail below low threshold
    input wire logic battery_low_threshold, // Battery below low level
    input wire logic pre_uvh_cmp, // Feedback below UV high level
    input wire logic pre_uvl_cmp, // Feedback below UV low level
    input wire logic pre_ov_cmp, // Feedback above OV level
    input wire logic ext_sync_in, // External sync clock
    input wire logic clk_src_wr, // Serial-bus source command strobe
    input wire logic clk_src_ext_cmd, // Commanded source, 1 = external
    input wire logic oc_sense, // Overcurrent comparator
    input wire logic peak_trip, // Peak current end of on-phase
    input wire logic duty_below_min, // Required duty under minimum
    output logic [7:0] core_io_fault_filter_cfg, // First filter byte
    output logic [7:0] aux_monitor_fault_filter_cfg, // Second filter byte
    output logic core_uv_fault, // Qualified core undervoltage
    output logic core_ov_fault, // Qualified core overvoltage
    output logic io_uv_fault, // Qualified I/O undervoltage
    output logic io_ov_fault, // Qualified I/O overvoltage
    output logic aux_uv_fault, // Qualified aux undervoltage
    output logic aux_ov_fault, // Qualified aux overvoltage
    output logic bias_uv_low_flag, // Qualified bias low undervoltage
    output logic power_down, // Full power-down request
    output logic bias_from_battery, // Direct battery-to-bias path on
    output logic bias_from_prereg, // Bias drawn from pre-regulator
    output logic pre_uvh_flag, // Feedback UV high to state machine
    output logic pre_uvl_flag, // Feedback UV low to state machine
    output logic pre_ov_flag, // Feedback OV to state machine
    output logic clk_src_ext, // Switching clock follows sync input
    output logic sw_clk, // Switching clock
    output logic high_side_switch // High-side gate command
);
    import sff_pkg::*;

    // ----------------------------------------
    // Configuration bytes
    // ----------------------------------------
    wire ld_core_io = cfg_load && cfg_addr == OFS_CORE_IO_FILT;
    wire ld_aux = cfg_load && cfg_addr == OFS_AUX_FILT;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            core_io_fault_filter_cfg <= CFG_RESET;
        end else if (ld_core_io) begin
            core_io_fault_filter_cfg <= cfg_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            aux_monitor_fault_filter_cfg <= CFG_RESET;
        end else if (ld_aux) begin
            aux_monitor_fault_filter_cfg <= cfg_data;
        end
    end

    // ----------------------------------------
    // Duration selection
    // ----------------------------------------
    wire [1:0] core_uv_filter_sel =
        core_io_fault_filter_cfg[CORE_UV_LSB +: 2];
    wire core_ov_filter_sel = core_io_fault_filter_cfg[CORE_OV_BIT];
    wire [1:0] io_uv_filter_sel = core_io_fault_filter_cfg[IO_UV_LSB +: 2];
    wire io_ov_filter_sel = core_io_fault_filter_cfg[IO_OV_BIT];
    wire [1:0] aux_uv_filter_sel =
        aux_monitor_fault_filter_cfg[AUX_UV_LSB +: 2];
    wire aux_ov_filter_sel = aux_monitor_fault_filter_cfg[AUX_OV_BIT];

    function automatic logic [DUR_W-1:0] uv_dur(input logic [1:0] sel);
        logic [DUR_W-1:0] d;
        d = DUR_W'(CYC_5US);
        unique case (sel)
            UV_SEL_5: d = DUR_W'(CYC_5US);
            UV_SEL_15: d = DUR_W'(CYC_15US);
            UV_SEL_25: d = DUR_W'(CYC_25US);
            UV_SEL_40: d = UV40_CYC;
        endcase
        return d;
    endfunction

    wire [DUR_W-1:0] core_uv_dur = uv_dur(core_uv_filter_sel);
    wire [DUR_W-1:0] core_ov_dur =
        core_ov_filter_sel ? OV45_CYC : DUR_W'(CYC_25US);
    wire [DUR_W-1:0] io_uv_dur = uv_dur(io_uv_filter_sel);
    wire [DUR_W-1:0] io_ov_dur =
        io_ov_filter_sel ? OV45_CYC : DUR_W'(CYC_25US);
    wire [DUR_W-1:0] aux_uv_dur = uv_dur(aux_uv_filter_sel);
    wire [DUR_W-1:0] aux_ov_dur =
        aux_ov_filter_sel ? OV45_CYC : DUR_W'(CYC_25US);
    wire [DUR_W-1:0] bias_dur = DUR_W'(CYC_BIAS_UV);
    wire [DUR_W-1:0] pre_uv_dur = DUR_W'(CYC_PRE_UV);
    wire [DUR_W-1:0] pre_ov_dur = DUR_W'(CYC_PRE_OV);

    // ----------------------------------------
    // Qualification filters
    // ----------------------------------------
    sff_filter u_core_uv (.sys_clk(sys_clk), .nrst(nrst),
        .cond(core_uv_cmp), .dur(core_uv_dur), .flag(core_uv_fault));
    sff_filter u_core_ov (.sys_clk(sys_clk), .nrst(nrst),
        .cond(core_ov_cmp), .dur(core_ov_dur), .flag(core_ov_fault));
    sff_filter u_io_uv (.sys_clk(sys_clk), .nrst(nrst),
        .cond(io_uv_cmp), .dur(io_uv_dur), .flag(io_uv_fault));
    sff_filter u_io_ov (.sys_clk(sys_clk), .nrst(nrst),
        .cond(io_ov_cmp), .dur(io_ov_dur), .flag(io_ov_fault));
    sff_filter u_aux_uv (.sys_clk(sys_clk), .nrst(nrst),
        .cond(aux_uv_cmp), .dur(aux_uv_dur), .flag(aux_uv_fault));
    sff_filter u_aux_ov (.sys_clk(sys_clk), .nrst(nrst),
        .cond(aux_ov_cmp), .dur(aux_ov_dur), .flag(aux_ov_fault));
    sff_filter u_bias_uv (.sys_clk(sys_clk), .nrst(nrst),
        .cond(bias_uv_low_cmp), .dur(bias_dur), .flag(bias_uv_low_flag));
    // Feedback results are qualified, then go out as state machine conditions
    sff_filter u_pre_uvh (.sys_clk(sys_clk), .nrst(nrst),
        .cond(pre_uvh_cmp), .dur(pre_uv_dur), .flag(pre_uvh_flag));
    sff_filter u_pre_uvl (.sys_clk(sys_clk), .nrst(nrst),
        .cond(pre_uvl_cmp), .dur(pre_uv_dur), .flag(pre_uvl_flag));
    sff_filter u_pre_ov (.sys_clk(sys_clk), .nrst(nrst),
        .cond(pre_ov_cmp), .dur(pre_ov_dur), .flag(pre_ov_flag));

    // ----------------------------------------
    // Bias supply and power-down
    // ----------------------------------------
    // Power-down holds until reset: bias may recover but state is lost
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            power_down <= 1'b0;
        end else if (bias_uv_low_flag) begin
            power_down <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            bias_from_battery <= 1'b1;
            bias_from_prereg <= 1'b0;
        end else begin
            bias_from_battery <= battery_low_threshold;
            bias_from_prereg <= !battery_low_threshold;
        end
    end

    // ----------------------------------------
    // Switching clock
    // ----------------------------------------
    logic [DIV_W-1:0] div_cnt;
    logic ext_prev;
    wire [DIV_W-1:0] div_last = pulse_skip_mode ?
        DIV_W'(CYC_APS - 1) : DIV_W'(CYC_PWM - 1);
    wire int_tick = div_cnt >= div_last;
    wire ext_rise = ext_sync_in && !ext_prev;
    wire sw_rise = clk_src_ext ? ext_rise : int_tick;
    wire int_high = div_cnt < (div_last >> 1);

    always_ff @(posedge sys_clk) begin
        if (!nrst || int_tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ext_prev <= 1'b0;
            clk_src_ext <= 1'b0;
            sw_clk <= 1'b0;
        end else begin
            ext_prev <= ext_sync_in;
            if (clk_src_wr) begin
                clk_src_ext <= clk_src_ext_cmd;
            end
            sw_clk <= clk_src_ext ? ext_sync_in : int_high;
        end
    end

    // ----------------------------------------
    // High-side switch
    // ----------------------------------------
    logic [ON_W-1:0] on_cnt;
    wire min_on_done = on_cnt >= ON_W'(CYC_HS_MIN);
    wire skip = pulse_skip_mode && duty_below_min;
    wire oc_off = high_side_switch && oc_sense && min_on_done;
    logic next_hs;

    always_comb begin
        next_hs = high_side_switch;
        if (power_down) begin
            next_hs = 1'b0;
        end else if (sw_rise) begin
            next_hs = !skip;
        end else if (oc_off || (high_side_switch && peak_trip)) begin
            next_hs = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            high_side_switch <= 1'b0;
            on_cnt <= '0;
        end else begin
            high_side_switch <= next_hs;
            if (!next_hs) begin
                on_cnt <= '0;
            end else if (!min_on_done) begin
                on_cnt <= on_cnt + ON_W'(1);
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_oc_late;
        high_side_switch && oc_sense && min_on_done && !sw_rise;
    endsequence

    a_core_uv_time: assert property (@(posedge sys_clk) disable iff (!nrst)
        core_uv_filter_sel == UV_SEL_15 |-> core_uv_dur == DUR_W'(CYC_15US))
        else $error("core undervoltage duration wrong");
    a_core_ov_time: assert property (@(posedge sys_clk) disable iff (!nrst)
        core_ov_dur == (core_ov_filter_sel ? OV45_CYC : DUR_W'(CYC_25US)))
        else $error("core overvoltage duration wrong");
    a_io_uv_time: assert property (@(posedge sys_clk) disable iff (!nrst)
        io_uv_filter_sel == UV_SEL_40 |-> io_uv_dur == UV40_CYC)
        else $error("I/O undervoltage duration wrong");
    a_io_ov_time: assert property (@(posedge sys_clk) disable iff (!nrst)
        !io_ov_filter_sel |-> io_ov_dur == DUR_W'(CYC_25US))
        else $error("I/O overvoltage duration wrong");
    a_aux_uv_time: assert property (@(posedge sys_clk) disable iff (!nrst)
        aux_uv_filter_sel == UV_SEL_5 |-> aux_uv_dur == DUR_W'(CYC_5US))
        else $error("aux undervoltage duration wrong");
    a_aux_ov_time: assert property (@(posedge sys_clk) disable iff (!nrst)
        aux_ov_filter_sel |-> aux_ov_dur == OV45_CYC)
        else $error("aux overvoltage duration wrong");
    a_bias_power_down: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        bias_uv_low_flag |=> power_down ##1 power_down && !high_side_switch)
        else $error("no power-down on bias undervoltage");
    a_bias_path_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 bias_from_battery == $past(battery_low_threshold)
        && bias_from_prereg != bias_from_battery)
        else $error("bias source does not follow battery");
    a_oc_turn_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_oc_late |=> !high_side_switch)
        else $error("overcurrent did not turn high side off");
    a_hs_on_at_edge: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(high_side_switch) |-> $past(sw_rise) && !$past(skip))
        else $error("high side turned on off the clock edge");
    a_src_by_cmd: assert property (@(posedge sys_clk) disable iff (!nrst)
        !clk_src_wr |=> $stable(clk_src_ext))
        else $error("clock source changed without command");
    a_mode_period: assert property (@(posedge sys_clk) disable iff (!nrst)
        int_tick && pulse_skip_mode && $stable(pulse_skip_mode)
        |-> $past(div_cnt) == DIV_W'(CYC_APS - 2))
        else $error("pulse skip period wrong");
    a_skip_turn_on: assert property (@(posedge sys_clk) disable iff (!nrst)
        sw_rise && skip |=> !high_side_switch)
        else $error("turn-on not skipped");
    a_pre_flags_out: assert property (@(posedge sys_clk) disable iff (!nrst)
        !pre_ov_cmp |=> !pre_ov_flag)
        else $error("feedback overvoltage flag stuck");
    a_pwm_period: assert property (@(posedge sys_clk) disable iff (!nrst)
        int_tick && !pulse_skip_mode && $stable(pulse_skip_mode)
        |-> $past(div_cnt) == DIV_W'(CYC_PWM - 2))
        else $error("forced PWM period wrong");
    a_src_takes_cmd: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_src_wr |=> clk_src_ext == $past(clk_src_ext_cmd))
        else $error("clock source command not taken");
    a_power_down_hold: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        power_down |=> power_down && !high_side_switch)
        else $error("power-down released or high side on");
    a_pwm_no_skip: assert property (@(posedge sys_clk) disable iff (!nrst)
        sw_rise && !pulse_skip_mode && !power_down |=> high_side_switch)
        else $error("turn-on missed in forced PWM");
endmodule

// >>> hdl/sff_pkg.sv
package sff_pkg;
    // ----------------------------------------
    // Configuration bytes and field layout
    // ----------------------------------------
    localparam logic [7:0] OFS_CORE_IO_FILT = 8'h10;
    localparam logic [7:0] OFS_AUX_FILT = 8'h11;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CORE_UV_LSB = 4;
    localparam int CORE_OV_BIT = 3;
    localparam int IO_UV_LSB = 1;
    localparam int IO_OV_BIT = 0;
    localparam int AUX_UV_LSB = 1;
    localparam int AUX_OV_BIT = 0;
    localparam logic [1:0] UV_SEL_5 = 2'h0;
    localparam logic [1:0] UV_SEL_15 = 2'h1;
    localparam logic [1:0] UV_SEL_25 = 2'h2;
    localparam logic [1:0] UV_SEL_40 = 2'h3;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int SYS_CLK_MHZ = 125;
    localparam int SYS_CLK_KHZ = 125000;
    localparam int DUR_W = 13;
    localparam int DGL_5US_NS = 5000;
    localparam int DGL_15US_NS = 15000;
    localparam int DGL_25US_NS = 25000;
    localparam int DGL_40US_NS = 40000;
    localparam int DGL_45US_NS = 45000;
    localparam int BIAS_UV_NS = 10000;
    localparam int PRE_UV_NS = 10000;
    localparam int PRE_OV_NS = 2000;
    localparam int HS_MIN_ON_NS = 25;
    localparam int PWM_FREQ_KHZ = 455;
    localparam int APS_FREQ_KHZ = 2220;

    // Least times round up to whole cycles
    localparam int CYC_5US = (DGL_5US_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CYC_15US = (DGL_15US_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CYC_25US = (DGL_25US_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CYC_40US = (DGL_40US_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CYC_45US = (DGL_45US_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CYC_BIAS_UV = (BIAS_UV_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CYC_PRE_UV = (PRE_UV_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CYC_PRE_OV = (PRE_OV_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CYC_HS_MIN = (HS_MIN_ON_NS * SYS_CLK_MHZ + 999) / 1000;
    // Switching periods round down so the frequency is never below nominal
    localparam int CYC_PWM = SYS_CLK_KHZ / PWM_FREQ_KHZ;
    localparam int CYC_APS = SYS_CLK_KHZ / APS_FREQ_KHZ;
    localparam int DIV_W = 9;
    localparam int ON_W = 3;
endpackage

// >>> hdl/sff_filter.sv
`timescale 1ns/1ps
module sff_filter (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic cond, // Raw comparator condition
    input wire logic [sff_pkg::DUR_W-1:0] dur, // Qualification cycles
    output logic flag // Qualified fault
);
    import sff_pkg::*;

    logic [DUR_W-1:0] cnt;
    wire hit = cond && !flag && (cnt == dur - DUR_W'(1));

    // Any gap in the condition restarts the count
    always_ff @(posedge sys_clk) begin
        if (!nrst || !cond) begin
            cnt <= '0;
            flag <= 1'b0;
        end else if (hit) begin
            flag <= 1'b1;
        end else if (!flag) begin
            cnt <= cnt + DUR_W'(1);
        end
    end

    a_flag_needs_time: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(flag) |-> $past(cond) && $past(cnt) == $past(dur) - DUR_W'(1))
        else $error("fault flag set before its duration");
    a_flag_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
        !cond |=> !flag && cnt == '0)
        else $error("filter did not restart on clear");
endmodule

// >>> verification/sff_stage_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Power stage and comparator side model
// ----------------------------------------
// The peak current comparator trips a fixed count after turn-on, which
// stands in for inductor ramp; overcurrent is only raised when the bench
// asks for it, and only while the high side conducts.
module sff_stage_model #(
    parameter int PEAK_CYC = 20,
    parameter int SYNC_HALF = 20
) (
    input wire logic sys_clk, // System clock
    input wire logic high_side_switch, // Gate command from the block
    input wire logic oc_force, // Bench request for overcurrent
    output logic oc_sense, // Overcurrent comparator
    output logic peak_trip, // Peak current comparator
    output logic ext_sync_in // Free running external sync clock
);
    int on_cnt = 0;
    int sync_cnt = 0;

    initial begin
        oc_sense = 1'b0;
        peak_trip = 1'b0;
        ext_sync_in = 1'b0;
    end

    always @(posedge sys_clk) begin
        #1;
        if (high_side_switch === 1'b1) begin
            on_cnt++;
        end else begin
            on_cnt = 0;
        end
        peak_trip = (on_cnt >= PEAK_CYC);
        oc_sense = oc_force && (on_cnt > 0);
        sync_cnt++;
        if (sync_cnt >= SYNC_HALF) begin
            sync_cnt = 0;
            ext_sync_in = ~ext_sync_in;
        end
    end
endmodule

// >>> verification/sff_ctrl_tb_top.sv
`timescale 1ns/1ps
module sff_ctrl_tb_top;
    import sff_pkg::*;
    localparam int SYNC_PER = 40;
    // Long filter times shortened to keep the run brief
    localparam int UV40 = 40;
    localparam int OV45 = 45;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg_load = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_data = 8'h00;
    logic psm = 1'b0;
    logic [9:0] cond = '0;
    logic bat_low = 1'b1;
    logic src_wr = 1'b0;
    logic src_cmd = 1'b0;
    logic dbm = 1'b0;
    logic oc_force = 1'b0;
    logic ext_sync_in, oc_sense, peak_trip;
    logic [7:0] cfg1, cfg2;
    logic [9:0] flt;
    logic power_down, bfb, bfp, clk_src_ext, sw_clk, hs;
    int miscompares = 0;
    int total_checks = 0;

    always #4 sys_clk = ~sys_clk;

    sff_ctrl #(.UV40_CYC(13'(UV40)), .OV45_CYC(13'(OV45))) u_sff_ctrl (
        .sys_clk(sys_clk), .nrst(nrst), .cfg_load(cfg_load),
        .cfg_addr(cfg_addr), .cfg_data(cfg_data), .pulse_skip_mode(psm),
        .core_uv_cmp(cond[0]), .core_ov_cmp(cond[1]), .io_uv_cmp(cond[2]),
        .io_ov_cmp(cond[3]), .aux_uv_cmp(cond[4]), .aux_ov_cmp(cond[5]),
        .pre_uvh_cmp(cond[6]), .pre_uvl_cmp(cond[7]), .pre_ov_cmp(cond[8]),
        .bias_uv_low_cmp(cond[9]), .battery_low_threshold(bat_low),
        .ext_sync_in(ext_sync_in), .clk_src_wr(src_wr),
        .clk_src_ext_cmd(src_cmd), .oc_sense(oc_sense),
        .peak_trip(peak_trip), .duty_below_min(dbm),
        .core_io_fault_filter_cfg(cfg1), .aux_monitor_fault_filter_cfg(cfg2),
        .core_uv_fault(flt[0]), .core_ov_fault(flt[1]), .io_uv_fault(flt[2]),
        .io_ov_fault(flt[3]), .aux_uv_fault(flt[4]), .aux_ov_fault(flt[5]),
        .pre_uvh_flag(flt[6]), .pre_uvl_flag(flt[7]), .pre_ov_flag(flt[8]),
        .bias_uv_low_flag(flt[9]), .power_down(power_down),
        .bias_from_battery(bfb), .bias_from_prereg(bfp),
        .clk_src_ext(clk_src_ext), .sw_clk(sw_clk), .high_side_switch(hs)
    );

    sff_stage_model #(.PEAK_CYC(20), .SYNC_HALF(SYNC_PER / 2))
        u_sff_stage_model (
        .sys_clk(sys_clk), .high_side_switch(hs), .oc_force(oc_force),
        .oc_sense(oc_sense), .peak_trip(peak_trip), .ext_sync_in(ext_sync_in)
    );

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task tick;
        @(posedge sys_clk);
        #1;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task conclude;
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task cfg(input logic [7:0] a, input logic [7:0] d);
        cfg_load = 1'b1;
        cfg_addr = a;
        cfg_data = d;
        tick;
        cfg_load = 1'b0;
        // Strobe low for one edge so back-to-back loads stay distinct
        tick;
    endtask

    // Undervoltage filter cycles per two-bit code
    function automatic int uvd(input logic [1:0] c);
        case (c)
            2'h0: return CYC_5US;
            2'h1: return CYC_15US;
            2'h2: return CYC_25US;
            default: return UV40;
        endcase
    endfunction

    // One short burst that must not qualify, then a full one
    task filt(input int i, input int n);
        cond[i] = 1'b1;
        repeat (n - 1) tick;
        chk(flt[i], 0);
        cond[i] = 1'b0;
        tick;
        cond[i] = 1'b1;
        repeat (n - 1) tick;
        chk(flt[i], 0);
        tick;
        chk(flt[i], 1);
        cond[i] = 1'b0;
        tick;
        chk(flt[i], 0);
    endtask

    function automatic logic pick(input int s);
        return s ? hs : sw_clk;
    endfunction

    // Ticks until the selected signal next goes from low to high
    task rise(input int s, output int n);
        n = 0;
        while (pick(s) !== 1'b0 && n < 1000) begin
            tick;
            n++;
        end
        while (pick(s) !== 1'b1 && n < 1000) begin
            tick;
            n++;
        end
    endtask

    task per(input int exp);
        int n;
        rise(0, n);
        rise(0, n);
        chk(n, exp);
    endtask

    task hsw(input int lo, input int hi, input int p);
        int w, l;
        w = 0;
        l = 0;
        rise(1, w);
        w = 0;
        while (hs === 1'b1 && w < 1000) begin
            tick;
            w++;
        end
        while (hs === 1'b0 && l < 1000) begin
            tick;
            l++;
        end
        chk(w >= lo && w <= hi, 1);
        chk(w + l, p);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_cfg;
        cfg(8'h10, 8'h3F);
        cfg(8'h11, 8'h07);
        cfg(8'h12, 8'hFF);
        chk(cfg1, 8'h3F);
        chk(cfg2, 8'h07);
    endtask

    task t_bias_sel;
        bat_low = 1'b0;
        tick;
        chk({bfb, bfp}, 2'b01);
        bat_low = 1'b1;
        tick;
        chk({bfb, bfp}, 2'b10);
    endtask

    task t_clk_src;
        per(CYC_PWM);
        psm = 1'b1;
        per(CYC_APS);
        repeat (300) tick;
        chk(clk_src_ext, 0);
        src_cmd = 1'b1;
        src_wr = 1'b1;
        tick;
        src_wr = 1'b0;
        chk(clk_src_ext, 1);
        per(SYNC_PER);
        src_cmd = 1'b0;
        src_wr = 1'b1;
        tick;
        src_wr = 1'b0;
        chk(clk_src_ext, 0);
        per(CYC_APS);
        psm = 1'b0;
    endtask

    task t_high_side;
        hsw(20, 22, CYC_PWM);
        oc_force = 1'b1;
        hsw(4, 6, CYC_PWM);
        oc_force = 1'b0;
        psm = 1'b1;
        dbm = 1'b1;
        repeat (3) per(CYC_APS);
        chk(hs, 0);
        dbm = 1'b0;
        hsw(20, 22, CYC_APS);
        psm = 1'b0;
    endtask

    task t_filters;
        for (int c = 0; c < 4; c++) begin
            cfg(8'h10, 8'(c << 4));
            filt(0, uvd(2'(c)));
        end
        filt(1, CYC_25US);
        cfg(8'h10, 8'h08);
        filt(1, OV45);
        cfg(8'h10, 8'h02);
        filt(2, uvd(2'h1));
        filt(3, CYC_25US);
        cfg(8'h10, 8'h07);
        filt(2, uvd(2'h3));
        filt(3, OV45);
        cfg(8'h11, 8'h02);
        filt(4, uvd(2'h1));
        filt(5, CYC_25US);
        cfg(8'h11, 8'h01);
        filt(4, uvd(2'h0));
        filt(5, OV45);
        filt(6, CYC_PRE_UV);
        filt(7, CYC_PRE_UV);
        filt(8, CYC_PRE_OV);
    endtask

    task t_power_down;
        filt(9, CYC_BIAS_UV);
        chk(power_down, 1);
        repeat (2) per(CYC_PWM);
        chk(hs, 0);
        nrst = 1'b0;
        tick;
        nrst = 1'b1;
        chk({power_down, cfg1, cfg2}, 17'h0);
    endtask

    initial begin
        repeat (3) tick;
        chk({cfg1, cfg2, flt, power_down, bfb, bfp, clk_src_ext, hs},
            {26'h0, 1'b0, 1'b1, 3'h0});
        tick;
        nrst = 1'b1;
        tick;
        t_cfg;
        t_bias_sel;
        t_clk_src;
        t_high_side;
        t_filters;
        t_power_down;
        conclude;
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        miscompares++;
        conclude;
    end
endmodule
